// File: include/msc_pkg.sv
package msc_pkg;

  // ********************************************************************
  // Register offsets and reset values.
  // ********************************************************************
  localparam logic [7:0] SFR_P0 = 8'h80;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_POWER_CONTROL_REG = 8'h87;
  localparam logic [7:0] SFR_AUX_CONTROL_REG = 8'h8e;
  localparam logic [7:0] SFR_SERIAL_BUFFER_REG = 8'h99;
  localparam logic [7:0] SFR_P2 = 8'ha0;
  localparam logic [7:0] SFR_XPAGE = 8'ha1;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] SFR_RST = 8'h00;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int POWER_CONTROL_REG_IDL = 0;
  localparam int POWER_CONTROL_REG_PD = 1;
  localparam int POWER_CONTROL_REG_POF = 4;
  localparam logic [7:0] POWER_CONTROL_REG_WMASK = 8'hdf;
  localparam int AUX_CONTROL_REG_AUX_OFF = 1;
  localparam int XPAGE_BITS = 2;

  // ********************************************************************
  // Memory map limits.
  // ********************************************************************
  localparam logic [7:0] IRAM_DIRECT_TOP = 8'h7f;
  localparam logic [15:0] AUX_TOP = 16'h03ff;
  localparam int AUX_DEPTH = 1024;
  localparam int IRAM_DEPTH = 256;

  // ********************************************************************
  // Timing in oscillator clocks.
  // ********************************************************************
  localparam logic [3:0] OSC_PER_MC = 4'hc;
  localparam logic [3:0] ALE_DIV = 4'h6;
  localparam logic [3:0] ALE_HIGH = 4'h2;
  localparam logic [3:0] STATE5_PHASE2_SAMPLE_PHASE = 4'h9;
  localparam logic [1:0] RST_SAMPLES = 2'h2;

  // ********************************************************************
  // Types.
  // ********************************************************************
  typedef enum logic [1:0] {
    ACC_IRAM_DIR = 2'b00,
    ACC_IRAM_IND = 2'b01,
    ACC_XDATA_RI = 2'b10,
    ACC_XDATA_DATA_POINTER_PAIR = 2'b11
  } msc_acc_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_STROBE = 2'b10
  } msc_bus_e;

  typedef struct packed {
    logic valid;
    msc_acc_e kind;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } msc_dreq_s;

  typedef struct packed {
    logic fetch;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } msc_extop_s;

endpackage

// File: design/msc_sysctl.sv
// Notes on behaviour
// R1 - Aux RAM on while aux-off bit clear
// R2 - Low half direct/indirect, upper half indirect only
// R3 - Aux RAM serves external-data moves to 3FFH
// R4 - Higher external-data addresses use the port bus
// R5 - Index-pointer moves hit aux RAM while it is on
// R6 - Aux accesses leave ports and strobes alone
// R7 - Page-high supplies upper bits, two effective
// R8 - Idle stops processor clock only
// R9 - Idle ends on interrupt or reset
// R10 - Power-down stops every clock
// R11 - Power-down ends on reset or enabled external irq
// R12 - Reset pin sampled at STATE5_PHASE2_SAMPLE, filtered
// R13 - Outside holds reset two machine cycles
// R14 - Reset loads ports FFH, stack 07H, rest 00H
// R15 - Reset keeps serial buffer and power-on flag
// R16 - Address latch strobe at one sixth oscillator
// R17 - Fetch strobe only for external fetches
// R18 - Fetch select pin picks internal or external
// R19 - Port 2 high address, port 0 low/data
// R20 - Integrator may clear emission option bit
// R21 - Machine cycle is twelve oscillator clocks
// R22 - Power-on flag set at power-on, clearable
// R23 - Power-down bit 1, idle bit 0
// R24 - Wake-up clears the request bit
module msc_sysctl
  import msc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic ext_fetch_select,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_zero_en,
  input wire logic ext_irq_one_en,
  input wire logic irq_any,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire msc_dreq_s dreq,
  output logic d_ack,
  output logic [7:0] d_rdata,
  output logic bus_busy,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic fetch_ack,
  output logic [7:0] fetch_data,
  output logic sys_reset,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic ale,
  output logic program_fetch_strobe_n,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  output logic [7:0] p2_out
);

  // ********************************************************************
  // Pin synchronisers.
  // ********************************************************************
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [7:0] p0_meta;
  logic [7:0] p0_sync;

  always_ff @(posedge core_clk) begin
    pin_meta <= {reset_pin, ext_fetch_select, ext_irq_zero, ext_irq_one};
    pin_sync <= pin_meta;
    p0_meta <= p0_in;
    p0_sync <= p0_meta;
  end

  logic rst_pin_s;
  logic fetch_sel_s;
  logic irq0_s;
  logic irq1_s;
  assign rst_pin_s = pin_sync[3];
  assign fetch_sel_s = pin_sync[2];
  assign irq0_s = pin_sync[1];
  assign irq1_s = pin_sync[0];

  // ********************************************************************
  // Machine cycle phase counter.
  // ********************************************************************
  logic [3:0] phase;
  logic [3:0] phase6;
  logic [3:0] next_phase;
  logic pd_mode;
  logic idl_mode;

  assign phase6 = (phase >= ALE_DIV) ? phase - ALE_DIV : phase;
  // Power-down freezes the oscillator, so the phase stands still.
  assign next_phase = pd_mode ? phase :
    ((phase == OSC_PER_MC - 4'h1) ? 4'h0 : phase + 4'h1); // see R21 R10

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= OSC_PER_MC - 4'h1;
    end else begin
      phase <= next_phase;
    end
  end

  // ********************************************************************
  // Reset pin filter.
  // ********************************************************************
  logic [1:0] rst_count;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rst_count <= 2'h0;
    end else if (!rst_pin_s) begin
      rst_count <= 2'h0;
    end else if (phase == STATE5_PHASE2_SAMPLE_PHASE && !pd_mode &&
                 rst_count != RST_SAMPLES) begin
      rst_count <= rst_count + 2'h1; // see R12 R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (rst_count == RST_SAMPLES); // see R12
    end
  end

  logic any_rst;
  assign any_rst = !rst_n || sys_reset;

  // ********************************************************************
  // Special function registers.
  // ********************************************************************
  logic [7:0] p0_latch;
  logic [7:0] p2_latch;
  logic [7:0] sp;
  logic [7:0] dpl;
  logic [7:0] dph;
  logic [7:0] power_control_reg;
  logic [7:0] aux_control_reg;
  logic [7:0] aux_ram_page_high;
  logic [7:0] serial_buffer_reg;
  logic aux_on;
  logic wake_idle;
  logic wake_pd;

  assign aux_on = !aux_control_reg[AUX_CONTROL_REG_AUX_OFF]; // see R1
  assign idl_mode = power_control_reg[POWER_CONTROL_REG_IDL]; // see R23
  assign pd_mode = power_control_reg[POWER_CONTROL_REG_PD]; // see R23
  assign wake_idle = irq_any; // see R9
  assign wake_pd = (irq0_s && ext_irq_zero_en) ||
    (irq1_s && ext_irq_one_en) || rst_pin_s; // see R11

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      p0_latch <= PORT_RST; // see R14
      p2_latch <= PORT_RST;
      sp <= SP_RST;
      dpl <= SFR_RST;
      dph <= SFR_RST;
      aux_control_reg <= SFR_RST; // see R1
      aux_ram_page_high <= SFR_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        SFR_P0: p0_latch <= reg_wdata;
        SFR_P2: p2_latch <= reg_wdata;
        SFR_SP: sp <= reg_wdata;
        SFR_DPL: dpl <= reg_wdata;
        SFR_DPH: dph <= reg_wdata;
        SFR_AUX_CONTROL_REG: aux_control_reg <= reg_wdata;
        SFR_XPAGE: aux_ram_page_high <= reg_wdata;
        default: ;
      endcase
    end
  end

  // The serial buffer has no reset at all.
  always_ff @(posedge core_clk) begin
    if (reg_wr && reg_addr == SFR_SERIAL_BUFFER_REG) begin
      serial_buffer_reg <= reg_wdata; // see R15
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      power_control_reg <= 8'h00 | (8'h01 << POWER_CONTROL_REG_POF); // see R22
    end else if (sys_reset) begin
      power_control_reg <= power_control_reg &
        (8'h01 << POWER_CONTROL_REG_POF); // see R14 R15
    end else if (reg_wr && reg_addr == SFR_POWER_CONTROL_REG) begin
      power_control_reg <= reg_wdata & POWER_CONTROL_REG_WMASK; // see R22 R23
    end else begin
      if (idl_mode && wake_idle) begin
        power_control_reg[POWER_CONTROL_REG_IDL] <= 1'b0; // see R24 R9
      end
      if (pd_mode && wake_pd) begin
        power_control_reg[POWER_CONTROL_REG_PD] <= 1'b0; // see R24 R11
      end
    end
  end

  // ********************************************************************
  // Clock gating controls.
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
    end else begin
      cpu_clk_en <= !idl_mode && !pd_mode; // see R8 R10
      periph_clk_en <= !pd_mode; // see R8 R10
      osc_en <= !pd_mode; // see R10
    end
  end

  // ********************************************************************
  // Register read port.
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        SFR_P0: reg_rdata <= p0_latch;
        SFR_P2: reg_rdata <= p2_latch;
        SFR_SP: reg_rdata <= sp;
        SFR_DPL: reg_rdata <= dpl;
        SFR_DPH: reg_rdata <= dph;
        SFR_POWER_CONTROL_REG: reg_rdata <= power_control_reg;
        SFR_AUX_CONTROL_REG: reg_rdata <= aux_control_reg;
        SFR_XPAGE: reg_rdata <= aux_ram_page_high;
        SFR_SERIAL_BUFFER_REG: reg_rdata <= serial_buffer_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ********************************************************************
  // Data access decode.
  // ********************************************************************
  logic [7:0] iram [IRAM_DEPTH];
  logic [7:0] aux_mem [AUX_DEPTH];
  logic [15:0] data_pointer_pair;
  logic take_d;
  logic to_iram;
  logic to_aux;
  logic to_ext;
  logic [9:0] aux_addr;
  logic [15:0] ext_addr;
  logic pend;
  msc_extop_s op;
  msc_bus_e bus_state;

  assign data_pointer_pair = {dph, dpl};
  assign bus_busy = pend || bus_state != BUS_IDLE;
  assign take_d = dreq.valid && !bus_busy && !any_rst;

  always_comb begin
    to_iram = 1'b0;
    to_aux = 1'b0;
    to_ext = 1'b0;
    aux_addr = 10'h000;
    ext_addr = 16'h0000;
    case (dreq.kind)
      ACC_IRAM_DIR: to_iram = dreq.addr[7:0] <= IRAM_DIRECT_TOP; // see R2
      ACC_IRAM_IND: to_iram = 1'b1; // see R2
      ACC_XDATA_RI: begin
        to_aux = aux_on; // see R5
        to_ext = !aux_on; // see R4
        aux_addr = {aux_ram_page_high[XPAGE_BITS-1:0],
                    dreq.addr[7:0]}; // see R7
        ext_addr = {p2_latch, dreq.addr[7:0]};
      end
      ACC_XDATA_DATA_POINTER_PAIR: begin
        to_aux = aux_on && data_pointer_pair <= AUX_TOP; // see R3
        to_ext = !(aux_on && data_pointer_pair <= AUX_TOP); // see R4
        aux_addr = data_pointer_pair[9:0];
        ext_addr = data_pointer_pair;
      end
      default: ;
    endcase
  end

  logic int_ack;
  logic [7:0] int_rdata;

  // Internal RAMs answer in the next cycle and never touch the pins.
  always_ff @(posedge core_clk) begin
    if (take_d && to_iram && dreq.wr) begin
      iram[dreq.addr[7:0]] <= dreq.wdata;
    end
    if (take_d && to_aux && dreq.wr) begin
      aux_mem[aux_addr] <= dreq.wdata; // see R3 R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_ack <= 1'b0;
      int_rdata <= 8'h00;
    end else begin
      int_ack <= take_d && !to_ext;
      if (take_d && to_iram) begin
        int_rdata <= iram[dreq.addr[7:0]];
      end else if (take_d && to_aux) begin
        int_rdata <= aux_mem[aux_addr];
      end else if (take_d) begin
        int_rdata <= 8'h00;
      end
    end
  end

  // ********************************************************************
  // External bus engine.
  // ********************************************************************
  logic take_f;
  logic bus_done;
  msc_bus_e next_bus;

  // Internal fetches are not taken, so nothing leaves on the bus.
  assign take_f = fetch_req && !fetch_sel_s && !bus_busy &&
    !dreq.valid && !any_rst; // see R18 R17

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      pend <= 1'b0;
      op <= '0;
    end else if (take_d && to_ext) begin
      pend <= 1'b1;
      op <= '{fetch: 1'b0, wr: dreq.wr, addr: ext_addr,
              wdata: dreq.wdata};
    end else if (take_f) begin
      pend <= 1'b1;
      op <= '{fetch: 1'b1, wr: 1'b0, addr: fetch_addr, wdata: 8'h00};
    end else if (bus_state == BUS_IDLE && next_bus == BUS_ADDR) begin
      pend <= 1'b0;
    end
  end

  always_comb begin
    next_bus = bus_state;
    bus_done = 1'b0;
    case (bus_state)
      BUS_IDLE:
        if (pend && next_phase == 4'h0 || pend && next_phase == ALE_DIV) begin
          next_bus = BUS_ADDR;
        end
      BUS_ADDR:
        if (!pd_mode && phase6 == ALE_HIGH - 4'h1) begin
          next_bus = BUS_STROBE;
        end
      BUS_STROBE:
        if (!pd_mode && phase6 == ALE_DIV - 4'h1) begin
          next_bus = BUS_IDLE;
          bus_done = 1'b1;
        end
      default: next_bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus;
    end
  end

  logic [3:0] next_phase6;
  assign next_phase6 = (next_phase >= ALE_DIV) ?
    next_phase - ALE_DIV : next_phase;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ale <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      rd_strobe_n <= 1'b1;
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p2_out <= PORT_RST;
    end else begin
      ale <= !pd_mode && next_phase6 < ALE_HIGH; // see R16
      program_fetch_strobe_n <= !(next_bus == BUS_STROBE &&
                                  op.fetch); // see R17
      wr_strobe_n <= !(next_bus == BUS_STROBE && op.wr);
      rd_strobe_n <= !(next_bus == BUS_STROBE && !op.wr && !op.fetch);
      case (next_bus)
        BUS_ADDR: begin
          p0_out <= op.addr[7:0]; // see R19
          p0_oe <= 8'hff;
          p2_out <= op.addr[15:8]; // see R19
        end
        BUS_STROBE: begin
          p0_out <= op.wdata;
          p0_oe <= op.wr ? 8'hff : 8'h00;
          p2_out <= op.addr[15:8];
        end
        default: begin
          // Open drain: a zero latch bit pulls the pin low.
          p0_out <= 8'h00; // see R6
          p0_oe <= ~p0_latch;
          p2_out <= p2_latch;
        end
      endcase
    end
  end

  // ********************************************************************
  // Answers to the core.
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      d_ack <= 1'b0;
      d_rdata <= 8'h00;
      fetch_ack <= 1'b0;
      fetch_data <= 8'h00;
    end else begin
      d_ack <= int_ack || bus_done && !op.fetch;
      fetch_ack <= bus_done && op.fetch;
      if (int_ack) begin
        d_rdata <= int_rdata;
      end else if (bus_done && !op.fetch) begin
        d_rdata <= op.wr ? 8'h00 : p0_sync;
      end
      if (bus_done && op.fetch) begin
        fetch_data <= p0_sync;
      end
    end
  end

endmodule

// File: tb/msc_checker.sv
module msc_checker
  import msc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic ext_fetch_select,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic irq_any,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic d_ack,
  input wire logic sys_reset,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_en,
  input wire logic ale,
  input wire logic program_fetch_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic [7:0] p2_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Fetch select watch and assertions.
  // ****************************************************************
  logic [4:0] sel_hi;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !ext_fetch_select) begin
      sel_hi <= 5'h00;
    end else if (sel_hi != 5'h1f) begin
      sel_hi <= sel_hi + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n || sys_reset);

  sequence idle_wr;
    reg_wr && reg_addr == SFR_POWER_CONTROL_REG && reg_wdata[POWER_CONTROL_REG_IDL] &&
      !reg_wdata[POWER_CONTROL_REG_PD];
  endsequence
  sequence pd_quiet;
    !osc_en && !reset_pin && !ext_irq_zero && !ext_irq_one && !reg_wr;
  endsequence
  sequence rd_pulse;
    !rd_strobe_n [*4] ##1 rd_strobe_n;
  endsequence

  chk_ale_cycle: assert property (
    disable iff (!rst_n || !osc_en)
    $rose(ale) |=> ale ##1 !ale [*4] ##1 ale)
    else $error("ale cycle wrong");
  chk_reset_port: assert property (
    disable iff (!rst_n)
    sys_reset && $past(sys_reset, 2) |-> p2_out == PORT_RST)
    else $error("port not reset");
  chk_rd_strobe: assert property (
    disable iff (!rst_n || sys_reset || !osc_en)
    $fell(rd_strobe_n) |-> rd_pulse)
    else $error("read strobe length");
  chk_ack_pulse: assert property (d_ack |=> !d_ack)
    else $error("ack not a pulse");
  chk_idle_periph: assert property (
    !cpu_clk_en && osc_en |-> periph_clk_en)
    else $error("peripheral clock stopped");
  chk_pd_clocks: assert property (
    !osc_en |-> !cpu_clk_en && !periph_clk_en && !ale)
    else $error("clock runs in power-down");
  chk_pd_stay: assert property (pd_quiet [*4] |=> !osc_en)
    else $error("power-down left without cause");
  chk_idle_enter: assert property (
    idle_wr ##1 !irq_any |=> !cpu_clk_en && osc_en)
    else $error("idle not entered");
  chk_idle_wake: assert property (
    !cpu_clk_en && osc_en && irq_any |-> ##[1:3] cpu_clk_en)
    else $error("idle not left");
  chk_fetch_quiet: assert property (
    sel_hi == 5'h1f |-> program_fetch_strobe_n)
    else $error("fetch strobe while internal");
endmodule

bind msc_sysctl msc_checker msc_checker_i (
  .core_clk, .rst_n, .reset_pin, .ext_fetch_select, .ext_irq_zero,
  .ext_irq_one, .irq_any, .reg_addr, .reg_wdata, .reg_wr, .d_ack,
  .sys_reset, .cpu_clk_en, .periph_clk_en, .osc_en, .ale,
  .program_fetch_strobe_n, .rd_strobe_n, .p2_out
);

// File: tb/msc_ext_mem.sv
module msc_ext_mem (
  input wire logic core_clk,
  input wire logic ale,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic program_fetch_strobe_n,
  output logic [7:0] p0_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // External program and data memory on the multiplexed bus.
  // ****************************************************************
  logic [7:0] mem [0:65535];
  logic [15:0] addr = 16'h0000;
  logic [7:0] last = 8'h00;
  logic [7:0] drv;

  always @(posedge core_clk) begin
    if (ale && p0_oe == 8'hff && rd_strobe_n && wr_strobe_n) begin
      addr <= {p2_out, p0_out};
    end
    if (!wr_strobe_n) begin
      mem[addr] <= p0_out;
    end
    last <= p0_in;
  end

  always_comb begin
    if (!program_fetch_strobe_n) begin
      drv = addr[15:8] ^ addr[7:0];
    end else if (!rd_strobe_n) begin
      drv = mem[addr];
    end else begin
      drv = ~last;
    end
    p0_in = (p0_out & p0_oe) | (drv & ~p0_oe);
  end
endmodule

// File: tb/tb_top.sv
`define CHK(act, exp) begin \
  num_checks++; \
  if ((act) !== (exp)) begin \
    miscompares++; \
    $display("ERROR at %0t: got %h want %h", $time, act, exp); \
  end \
end

module tb_top
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    msc_acc_e k;
    logic w;
    logic [15:0] dp;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic ext;
  } msc_row_s;

  // ****************************************************************
  // Stimulus, design and memory model.
  // ****************************************************************
  logic core_clk = 1'b0;
  logic rst_n, reset_pin, ext_fetch_select, ext_irq_zero;
  logic ext_irq_zero_en, irq_any, reg_wr, reg_rd, fetch_req;
  logic ext_irq_one, ext_irq_one_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d_rdata, fetch_data, q;
  logic [7:0] p0_in, p0_out, p0_oe, p2_out;
  logic [15:0] fetch_addr;
  msc_dreq_s dreq;
  logic d_ack, bus_busy, fetch_ack, sys_reset, cpu_clk_en, periph_clk_en;
  logic osc_en, ale, program_fetch_strobe_n, wr_strobe_n, rd_strobe_n;
  logic ale_q = 1'b0;
  int miscompares, num_checks, cyc, rdl, wrl, pfl, fak, srs, ales;
  logic [7:0] ra [10] = '{SFR_P0, SFR_P2, SFR_SP, SFR_DPL, SFR_DPH,
    SFR_AUX_CONTROL_REG, SFR_XPAGE, SFR_POWER_CONTROL_REG, SFR_SERIAL_BUFFER_REG, 8'hfe};
  logic [7:0] rv [10] = '{PORT_RST, PORT_RST, SP_RST, SFR_RST, SFR_RST,
    SFR_RST, SFR_RST, 8'h10, 8'haa, 8'h00};
  msc_row_s rows [14] = '{
    '{ACC_IRAM_DIR, 1'b1, 16'h0, 8'h10, 8'ha5, 8'h00, 1'b0},
    '{ACC_IRAM_IND, 1'b0, 16'h0, 8'h10, 8'h00, 8'ha5, 1'b0},
    '{ACC_IRAM_IND, 1'b1, 16'h0, 8'h90, 8'h3c, 8'h00, 1'b0},
    '{ACC_IRAM_IND, 1'b0, 16'h0, 8'h90, 8'h00, 8'h3c, 1'b0},
    '{ACC_IRAM_DIR, 1'b0, 16'h0, 8'h90, 8'h00, 8'h00, 1'b0},
    '{ACC_XDATA_RI, 1'b1, 16'h0, 8'h34, 8'h56, 8'h00, 1'b0},
    '{ACC_XDATA_RI, 1'b0, 16'h0, 8'h34, 8'h00, 8'h56, 1'b0},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b0, 16'h0234, 8'h0, 8'h00, 8'h56, 1'b0},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b1, 16'h03ff, 8'h0, 8'h42, 8'h00, 1'b0},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b1, 16'h0400, 8'h0, 8'h43, 8'h00, 1'b1},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b0, 16'h03ff, 8'h0, 8'h00, 8'h42, 1'b0},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b0, 16'h0400, 8'h0, 8'h00, 8'h43, 1'b1},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b1, 16'h1234, 8'h0, 8'h99, 8'h00, 1'b1},
    '{ACC_XDATA_DATA_POINTER_PAIR, 1'b0, 16'h1234, 8'h0, 8'h00, 8'h99, 1'b1}};

  msc_sysctl msc_sysctl_i (.core_clk, .rst_n, .reset_pin,
    .ext_fetch_select, .ext_irq_zero, .ext_irq_one,
    .ext_irq_zero_en, .ext_irq_one_en, .irq_any, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dreq, .d_ack, .d_rdata,
    .bus_busy, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data,
    .sys_reset, .cpu_clk_en, .periph_clk_en, .osc_en, .ale,
    .program_fetch_strobe_n, .wr_strobe_n, .rd_strobe_n, .p0_in,
    .p0_out, .p0_oe, .p2_out);

  msc_ext_mem msc_ext_mem_i (.core_clk, .ale, .p0_out, .p0_oe, .p2_out,
    .rd_strobe_n, .wr_strobe_n, .program_fetch_strobe_n, .p0_in);

  always #4 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    cyc++;
    rdl += !rd_strobe_n;
    wrl += !wr_strobe_n;
    pfl += !program_fetch_strobe_n;
    fak += fetch_ack;
    srs += sys_reset;
    ales += ale && !ale_q;
    ale_q = ale;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK(reg_rdata, e)
    @(posedge core_clk);
  endtask

  task automatic dx(input msc_acc_e k, input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] v);
    int n;
    n = 0;
    dreq <= '{1'b1, k, w, a, d};
    do begin
      @(negedge core_clk);
      n++;
    end while (bus_busy !== 1'b0 && n < 60);
    @(posedge core_clk);
    dreq.valid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (d_ack !== 1'b1 && n < 120);
    v = d_rdata;
    @(posedge core_clk);
  endtask

  initial begin
    int n;
    {rst_n, reset_pin, ext_irq_zero, ext_irq_zero_en, irq_any} = '0;
    {ext_irq_one, ext_irq_one_en} = '0;
    {reg_wr, reg_rd, fetch_req, reg_addr, reg_wdata, fetch_addr} = '0;
    dreq = '0;
    ext_fetch_select = 1'b1;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdc(SFR_POWER_CONTROL_REG, 8'h10);
    wr(SFR_XPAGE, 8'h06);
    foreach (rows[i]) begin
      wr(SFR_DPH, rows[i].dp[15:8]);
      wr(SFR_DPL, rows[i].dp[7:0]);
      rdl = 0;
      wrl = 0;
      dx(rows[i].k, rows[i].w, {8'h00, rows[i].a}, rows[i].d, q);
      if (!rows[i].w) `CHK(q, rows[i].q)
      `CHK(rows[i].w ? wrl : rdl, rows[i].ext ? 4 : 0)
    end
    wr(SFR_AUX_CONTROL_REG, 8'h02);
    dx(ACC_XDATA_RI, 1'b1, 16'h0034, 8'h11, q);
    `CHK(msc_ext_mem_i.mem[16'hff34], 8'h11)
    wr(SFR_AUX_CONTROL_REG, 8'h00);
    dx(ACC_XDATA_RI, 1'b0, 16'h0034, 8'h00, q);
    `CHK(q, 8'h56)
    wr(SFR_SP, 8'h55);
    wr(SFR_SERIAL_BUFFER_REG, 8'haa);
    wr(SFR_P2, 8'h5a);
    wr(SFR_POWER_CONTROL_REG, 8'h1c);
    srs = 0;
    reset_pin <= 1'b1;
    repeat (12) @(posedge core_clk);
    reset_pin <= 1'b0;
    repeat (20) @(posedge core_clk);
    `CHK(srs, 0)
    reset_pin <= 1'b1;
    repeat (30) @(posedge core_clk);
    reset_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    `CHK(srs > 0, 1'b1)
    foreach (ra[i]) rdc(ra[i], rv[i]);
    wr(SFR_POWER_CONTROL_REG, 8'h00);
    rdc(SFR_POWER_CONTROL_REG, 8'h00);
    wr(SFR_POWER_CONTROL_REG, 8'h01);
    repeat (3) @(negedge core_clk);
    `CHK({cpu_clk_en, periph_clk_en, osc_en}, 3'b011)
    @(posedge core_clk);
    irq_any <= 1'b1;
    repeat (4) @(posedge core_clk);
    irq_any <= 1'b0;
    @(negedge core_clk);
    `CHK(cpu_clk_en, 1'b1)
    @(posedge core_clk);
    rdc(SFR_POWER_CONTROL_REG, 8'h00);
    wr(SFR_POWER_CONTROL_REG, 8'h02);
    repeat (6) @(negedge core_clk);
    `CHK({osc_en, cpu_clk_en, periph_clk_en, ale}, 4'h0)
    @(posedge core_clk);
    ext_irq_zero <= 1'b1;
    repeat (8) @(negedge core_clk);
    `CHK(osc_en, 1'b0)
    @(posedge core_clk);
    ext_irq_zero_en <= 1'b1;
    repeat (6) @(negedge core_clk);
    `CHK(osc_en, 1'b1)
    @(posedge core_clk);
    {ext_irq_zero, ext_irq_zero_en} <= 2'b00;
    rdc(SFR_POWER_CONTROL_REG, 8'h00);
    wr(SFR_POWER_CONTROL_REG, 8'h02);
    @(negedge core_clk);
    `CHK(osc_en, 1'b0)
    @(posedge core_clk);
    {ext_irq_one, ext_irq_one_en} <= 2'b11;
    repeat (8) @(negedge core_clk);
    `CHK(osc_en, 1'b1)
    @(posedge core_clk);
    {ext_irq_one, ext_irq_one_en} <= 2'b00;
    rdc(SFR_POWER_CONTROL_REG, 8'h00);
    ales = 0;
    repeat (60) @(negedge core_clk);
    `CHK(ales, 10)
    @(posedge core_clk);
    ext_fetch_select <= 1'b0;
    repeat (4) @(posedge core_clk);
    pfl = 0;
    n = 0;
    fetch_addr <= 16'hbeef;
    fetch_req <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (bus_busy !== 1'b1 && n < 60);
    @(posedge core_clk);
    fetch_req <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (fetch_ack !== 1'b1 && n < 120);
    `CHK(fetch_data, 8'h51)
    `CHK(pfl, 4)
    @(posedge core_clk);
    ext_fetch_select <= 1'b1;
    repeat (4) @(posedge core_clk);
    pfl = 0;
    fak = 0;
    fetch_req <= 1'b1;
    repeat (30) @(posedge core_clk);
    fetch_req <= 1'b0;
    `CHK(pfl + fak, 0)
    test_done();
  end
endmodule
